// >>> hw/mrq_rx_ctrl.sv
// receive queue watermarks, latched status, frame filter and mac control
`timescale 1ns/1ns
module mrq_rx_ctrl import mrq_pkg::*; #(
   parameter logic [LVL_W-1:0] QUEUE_BYTES = QUEUE_BYTES_DEF
) (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic frame_done_i,
   input wire logic [13:0] frame_len_i,
   input wire mrq_frame_stat_t frame_stat_i,
   input wire logic rx_fifo_ovf_i,
   input wire logic drain_i,
   input wire logic [13:0] drain_len_i,
   output logic frame_accept_o,
   output logic frame_drop_o,
   output logic [LVL_W-1:0] queue_level_o,
   output logic irq_o,
   input wire logic tx_req_i,
   input wire logic tx_collision_i,
   input wire logic tx_done_i,
   output logic tx_start_o,
   output logic tx_skip_o,
   output logic tx_retry_err_o,
   output logic hb_check_en_o,
   output mrq_mac_cfg_t mac_cfg_o
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {TX_IDLE, TX_SEND} mrq_tx_state_t;

   logic [7:0] low_wm, next_low_wm, high_wm, next_high_wm;
   logic [3:0] irq_en, next_irq_en;
   logic [6:0] allow, next_allow;
   logic [15:0] ind_addr, next_ind_addr;
   logic [7:0] rdata, next_rdata;
   logic [3:0] lstat, next_lstat, set_vec;
   logic [LVL_W-1:0] level, next_level, lo_b, hi_b;
   logic [LVL_W:0] sum, sub;
   logic accept_p, next_accept_p, drop_p, next_drop_p;
   logic irq, next_irq;
   logic take, room, accept, q_ovf, hi_cross, lo_cross;
   logic rd_lstat, ind_ok, ctrl_wr, filt_reject;
   mrq_mac_cfg_t cfg;
   logic [7:0] ctrl_rbyte;
   mrq_tx_state_t tx_state, next_tx_state;
   logic [4:0] tries, next_tries;
   logic start_p, next_start_p, skip_p, next_skip_p, rerr_p, next_rerr_p;

   function automatic logic hits(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
      hits = (a == ofs);
   endfunction

   // ----------------------------------------------------------------
   // submodules
   // ----------------------------------------------------------------
   mrq_mac_ctrl u_ctrl (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .wr_i(ctrl_wr),
      .sel_i(ind_addr[1:0]),
      .wdata_i(reg_wdata_i),
      .cfg_o(cfg),
      .rbyte_o(ctrl_rbyte)
   );

   mrq_frame_filter u_filt (
      .stat_i(frame_stat_i),
      .allow_i(allow),
      .reject_o(filt_reject)
   );

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   always_comb begin
      ind_ok = (ind_addr < IND_CTRL_BYTES);
      ctrl_wr = reg_wr_i && hits(reg_addr_i, OFS_IND_DATA) && ind_ok;
      rd_lstat = reg_rd_i && hits(reg_addr_i, OFS_LSTAT);
      next_low_wm = low_wm;
      next_high_wm = high_wm;
      next_irq_en = irq_en;
      next_allow = allow;
      next_ind_addr = ind_addr;
      next_rdata = rdata;
      if (reg_wr_i) begin
         case (reg_addr_i)
            OFS_LOW_WM: next_low_wm = reg_wdata_i;
            OFS_HIGH_WM: next_high_wm = reg_wdata_i;
            OFS_IRQ_EN: next_irq_en = reg_wdata_i[3:0];
            OFS_REJECT: next_allow = reg_wdata_i[6:0];
            OFS_IND_ADDR_HI: next_ind_addr[15:8] = reg_wdata_i;
            OFS_IND_ADDR_LO: next_ind_addr[7:0] = reg_wdata_i;
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            OFS_LOW_WM: next_rdata = low_wm;
            OFS_HIGH_WM: next_rdata = high_wm;
            OFS_IRQ_EN: next_rdata = {4'h0, irq_en};
            OFS_LSTAT: next_rdata = {4'h0, lstat};
            OFS_REJECT: next_rdata = {1'b0, allow};
            OFS_IND_ADDR_HI: next_rdata = ind_addr[15:8];
            OFS_IND_ADDR_LO: next_rdata = ind_addr[7:0];
            OFS_IND_DATA: next_rdata = ind_ok ? ctrl_rbyte : RST_BYTE;
            default: next_rdata = RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_wm <= RST_BYTE;
         high_wm <= RST_BYTE;
         irq_en <= RST_BYTE[3:0];
         allow <= RST_BYTE[6:0];
         ind_addr <= 16'h0000;
         rdata <= RST_BYTE;
      end else begin
         low_wm <= next_low_wm;
         high_wm <= next_high_wm;
         irq_en <= next_irq_en;
         allow <= next_allow;
         ind_addr <= next_ind_addr;
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // queue level, watermarks and latched status
   // ----------------------------------------------------------------
   always_comb begin
      lo_b = LVL_W'(low_wm) * LVL_W'(WM_UNIT);
      hi_b = LVL_W'(high_wm) * LVL_W'(WM_UNIT);
      take = frame_done_i && cfg.rx_enable && !filt_reject;
      room = ({1'b0, level} + {12'h000, frame_len_i}) <= {1'b0, QUEUE_BYTES};
      accept = take && room;
      q_ovf = take && !room;
      sum = {1'b0, level} + (accept ? {12'h000, frame_len_i} : 26'h000_0000);
      sub = drain_i ? {12'h000, drain_len_i} : 26'h000_0000;
      // drain beyond what is held saturates rather than wrapping
      if (sum < sub) begin
         next_level = '0;
      end else begin
         next_level = LVL_W'(sum - sub);
      end
      hi_cross = (level < hi_b) && (next_level >= hi_b);
      lo_cross = (level >= lo_b) && (next_level < lo_b);
      set_vec = '0;
      set_vec[LS_FIFO_OVF] = rx_fifo_ovf_i;
      set_vec[LS_QUEUE_OVF] = q_ovf;
      set_vec[LS_HIGH] = hi_cross;
      set_vec[LS_LOW] = lo_cross;
      // a new event in the read cycle survives the clear
      next_lstat = (rd_lstat ? 4'h0 : lstat) | set_vec;
      next_accept_p = accept;
      next_drop_p = frame_done_i && !accept;
      // high and low sit in swapped places between status and enable
      next_irq = (lstat[LS_FIFO_OVF] && irq_en[EN_FIFO_OVF]) ||
                 (lstat[LS_QUEUE_OVF] && irq_en[EN_QUEUE_OVF]) ||
                 (lstat[LS_HIGH] && irq_en[EN_HIGH]) ||
                 (lstat[LS_LOW] && irq_en[EN_LOW]);
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         level <= '0;
         lstat <= 4'h0;
         accept_p <= 1'b0;
         drop_p <= 1'b0;
         irq <= 1'b0;
      end else begin
         level <= next_level;
         lstat <= next_lstat;
         accept_p <= next_accept_p;
         drop_p <= next_drop_p;
         irq <= next_irq;
      end
   end

   // ----------------------------------------------------------------
   // transmit gating and retry
   // ----------------------------------------------------------------
   always_comb begin
      next_tx_state = tx_state;
      next_tries = tries;
      next_start_p = 1'b0;
      next_skip_p = 1'b0;
      next_rerr_p = 1'b0;
      case (tx_state)
         TX_IDLE: begin
            if (tx_req_i && cfg.tx_enable) begin
               next_start_p = 1'b1;
               next_tries = 5'h01;
               next_tx_state = TX_SEND;
            end
         end
         TX_SEND: begin
            if (tx_collision_i) begin
               if (cfg.single_attempt) begin
                  next_skip_p = 1'b1;
                  next_tx_state = TX_IDLE;
               end else if (tries == MAX_TRIES) begin
                  next_rerr_p = 1'b1;
                  next_tx_state = TX_IDLE;
               end else begin
                  next_tries = tries + 5'h01;
                  next_start_p = 1'b1;
               end
            end else if (tx_done_i) begin
               next_tx_state = TX_IDLE;
            end
         end
         default: next_tx_state = TX_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_state <= TX_IDLE;
         tries <= 5'h00;
         start_p <= 1'b0;
         skip_p <= 1'b0;
         rerr_p <= 1'b0;
      end else begin
         tx_state <= next_tx_state;
         tries <= next_tries;
         start_p <= next_start_p;
         skip_p <= next_skip_p;
         rerr_p <= next_rerr_p;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata_o = rdata;
   assign frame_accept_o = accept_p;
   assign frame_drop_o = drop_p;
   assign queue_level_o = level;
   assign irq_o = irq;
   assign tx_start_o = start_p;
   assign tx_skip_o = skip_p;
   assign tx_retry_err_o = rerr_p;
   assign hb_check_en_o = !cfg.full_duplex && !cfg.heartbeat_off;
   assign mac_cfg_o = cfg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   property p_high_cross;
      (level >= $past(hi_b)) && ($past(level) < $past(hi_b)) |-> lstat[1];
   endproperty
   a_high_cross: assert property (p_high_cross)
      else $error("high crossing not latched in bit 1");

   property p_low_cross;
      (level < $past(lo_b)) && ($past(level) >= $past(lo_b)) |-> lstat[0];
   endproperty
   a_low_cross: assert property (p_low_cross)
      else $error("low crossing not latched in bit 0");

   property p_fifo_ovf;
      rx_fifo_ovf_i |=> lstat[3] ##1 (lstat[3] || $past(rd_lstat));
   endproperty
   a_fifo_ovf: assert property (p_fifo_ovf)
      else $error("fifo overflow not latched");

   property p_queue_ovf;
      frame_done_i && cfg.rx_enable && !filt_reject && !room
         |=> lstat[2] && !frame_accept_o && frame_drop_o;
   endproperty
   a_queue_ovf: assert property (p_queue_ovf)
      else $error("queue overflow not latched or frame kept");

   property p_read_clear;
      rd_lstat && (set_vec == 4'h0) |=> (lstat == 4'h0);
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("status read did not clear latched bits");

   property p_irq_swap;
      lstat[1] && irq_en[0] && !lstat[0] && !irq_en[1] |=> irq_o;
   endproperty
   a_irq_swap: assert property (p_irq_swap)
      else $error("high crossing with bit 0 enable gave no interrupt");

   property p_reject_hold;
      frame_done_i && filt_reject && !drain_i |=> $stable(level) && frame_drop_o;
   endproperty
   a_reject_hold: assert property (p_reject_hold)
      else $error("rejected frame moved the queue level");

   property p_rx_gate;
      frame_done_i && !cfg.rx_enable |=> !frame_accept_o;
   endproperty
   a_rx_gate: assert property (p_rx_gate)
      else $error("frame accepted with receive disabled");

   property p_tx_gate;
      (tx_state == TX_IDLE) && !cfg.tx_enable |=> !tx_start_o;
   endproperty
   a_tx_gate: assert property (p_tx_gate)
      else $error("transmit started while disabled");

   property p_single;
      (tx_state == TX_SEND) && tx_collision_i && cfg.single_attempt
         |=> tx_skip_o && !tx_start_o && (tx_state == TX_IDLE);
   endproperty
   a_single: assert property (p_single)
      else $error("single attempt mode retried");

   property p_retry_cap;
      (tx_state == TX_SEND) && tx_collision_i && !cfg.single_attempt &&
         (tries == 5'h10) |=> tx_retry_err_o && !tx_start_o;
   endproperty
   a_retry_cap: assert property (p_retry_cap)
      else $error("retry error not raised after 16 tries");

   property p_duplex_hb;
      cfg.full_duplex |-> !hb_check_en_o;
   endproperty
   a_duplex_hb: assert property (p_duplex_hb)
      else $error("heartbeat check active in full duplex");

   property p_cov_accept;
      frame_done_i ##1 frame_accept_o;
   endproperty
   c_accept: cover property (p_cov_accept);

   property p_cov_irq;
      hi_cross ##2 irq_o;
   endproperty
   c_irq: cover property (p_cov_irq);

   property p_cov_retry_err;
      tx_start_o ##[1:300] tx_retry_err_o;
   endproperty
   c_retry_err: cover property (p_cov_retry_err);

endmodule

// >>> hw/mrq_pkg.sv
// constants, field layouts and carrier types for the receive queue control
package mrq_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 9;
   localparam logic [8:0] OFS_IND_ADDR_HI = 9'h140;
   localparam logic [8:0] OFS_IND_ADDR_LO = 9'h141;
   localparam logic [8:0] OFS_IND_DATA = 9'h142;
   localparam logic [8:0] OFS_LOW_WM = 9'h15a;
   localparam logic [8:0] OFS_HIGH_WM = 9'h15b;
   localparam logic [8:0] OFS_IRQ_EN = 9'h15c;
   localparam logic [8:0] OFS_LSTAT = 9'h15d;
   localparam logic [8:0] OFS_REJECT = 9'h15e;
   localparam logic [15:0] IND_CTRL_BYTES = 16'h0004;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned EN_FIFO_OVF = 3;
   localparam int unsigned EN_QUEUE_OVF = 2;
   localparam int unsigned EN_LOW = 1;
   localparam int unsigned EN_HIGH = 0;
   localparam int unsigned LS_FIFO_OVF = 3;
   localparam int unsigned LS_QUEUE_OVF = 2;
   localparam int unsigned LS_HIGH = 1;
   localparam int unsigned LS_LOW = 0;
   localparam int unsigned RJ_NONPAUSE = 6;
   localparam int unsigned RJ_CTRL = 5;
   localparam int unsigned RJ_LENGTH = 4;
   localparam int unsigned RJ_CHECKSUM = 3;
   localparam int unsigned RJ_ODD_BIT = 2;
   localparam int unsigned RJ_PHY_ERR = 1;
   localparam int unsigned RJ_BROADCAST = 0;
   localparam int unsigned MC_HEARTBEAT_OFF = 28;
   localparam int unsigned MC_PORT_CHOICE = 27;
   localparam int unsigned MC_SELF_RX_BLOCK = 23;
   localparam int unsigned MC_LOOPBACK = 21;
   localparam int unsigned MC_DUPLEX = 20;
   localparam int unsigned MC_ACCEPT_ALL = 19;
   localparam int unsigned MC_MULTICAST = 18;
   localparam int unsigned MC_LATE_COL = 12;
   localparam int unsigned MC_SINGLE = 10;
   localparam int unsigned MC_PAD_STRIP = 8;
   localparam int unsigned MC_BACKOFF_HI = 7;
   localparam int unsigned MC_BACKOFF_LO = 6;
   localparam int unsigned MC_DEFERRAL = 5;
   localparam int unsigned MC_TX_EN = 3;
   localparam int unsigned MC_RX_EN = 2;
   localparam logic [31:0] MC_RW_MASK = 32'h18bc_15ec;

   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam int unsigned WM_PKTS = 32;
   localparam int unsigned WM_PKT_BYTES = 2048;
   localparam int unsigned WM_UNIT = WM_PKTS * WM_PKT_BYTES;
   localparam int unsigned LVL_W = 25;
   localparam logic [LVL_W-1:0] QUEUE_BYTES_DEF = 25'h100_0000;
   localparam logic [4:0] MAX_TRIES = 5'h10;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ctrl;
      logic unsup_ctrl;
      logic len_err;
      logic crc_err;
      logic dribble;
      logic phy_err;
      logic runt;
      logic collided;
      logic broadcast;
   } mrq_frame_stat_t;

   typedef struct packed {
      logic heartbeat_off;
      logic port_choice;
      logic self_receive_block;
      logic loopback_select;
      logic full_duplex;
      logic accept_all_frames;
      logic multicast_pass;
      logic late_collision_retry;
      logic single_attempt;
      logic auto_pad_strip;
      logic [1:0] backoff_limit;
      logic deferral_abort_check;
      logic tx_enable;
      logic rx_enable;
   } mrq_mac_cfg_t;

endpackage

// >>> hw/mrq_frame_filter.sv
// frame rejection filter: verdict from frame status and reject control
`timescale 1ns/1ns
module mrq_frame_filter import mrq_pkg::*; (
   input wire mrq_frame_stat_t stat_i,
   input wire logic [6:0] allow_i,
   output logic reject_o
);

   logic nonpause_ctrl_allow;
   logic ctrl_frame_allow;
   logic length_mismatch_allow;
   logic checksum_error_allow;
   logic odd_bit_frame_allow;
   logic phy_error_allow;
   logic broadcast_allow;

   always_comb begin
      nonpause_ctrl_allow = allow_i[RJ_NONPAUSE];
      ctrl_frame_allow = allow_i[RJ_CTRL];
      length_mismatch_allow = allow_i[RJ_LENGTH];
      checksum_error_allow = allow_i[RJ_CHECKSUM];
      odd_bit_frame_allow = allow_i[RJ_ODD_BIT];
      phy_error_allow = allow_i[RJ_PHY_ERR];
      broadcast_allow = allow_i[RJ_BROADCAST];
      reject_o = 1'b0;
      if (stat_i.ctrl && !ctrl_frame_allow) begin
         reject_o = 1'b1;
      end
      if (stat_i.ctrl && stat_i.unsup_ctrl && !nonpause_ctrl_allow) begin
         reject_o = 1'b1;
      end
      if (stat_i.len_err && !length_mismatch_allow) begin
         reject_o = 1'b1;
      end
      if ((stat_i.crc_err || stat_i.phy_err) && !checksum_error_allow) begin
         reject_o = 1'b1;
      end
      // dribble flag is meaningless on collided or runt frames
      if (stat_i.dribble && !stat_i.runt && !stat_i.collided &&
          !odd_bit_frame_allow) begin
         reject_o = 1'b1;
      end
      if (stat_i.phy_err && !phy_error_allow) begin
         reject_o = 1'b1;
      end
      if (stat_i.broadcast && !broadcast_allow) begin
         reject_o = 1'b1;
      end
   end

endmodule

// >>> hw/mrq_mac_ctrl.sv
// indirectly addressed 32-bit mac control word
`timescale 1ns/1ns
module mrq_mac_ctrl import mrq_pkg::*; (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic wr_i,
   input wire logic [1:0] sel_i,
   input wire logic [7:0] wdata_i,
   output mrq_mac_cfg_t cfg_o,
   output logic [7:0] rbyte_o
);

   logic [31:0] word;
   logic [31:0] next_word;

   // indirect byte 0 holds bits 31:24, byte 3 holds bits 7:0
   always_comb begin
      next_word = word;
      if (wr_i) begin
         next_word[31 - 8 * sel_i -: 8] = wdata_i;
      end
      next_word = next_word & MC_RW_MASK;
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         word <= RST_CTRL;
      end else begin
         word <= next_word;
      end
   end

   always_comb begin
      rbyte_o = word[31 - 8 * sel_i -: 8];
      cfg_o.heartbeat_off = word[MC_HEARTBEAT_OFF];
      cfg_o.port_choice = word[MC_PORT_CHOICE];
      cfg_o.self_receive_block = word[MC_SELF_RX_BLOCK];
      cfg_o.loopback_select = word[MC_LOOPBACK];
      cfg_o.full_duplex = word[MC_DUPLEX];
      cfg_o.accept_all_frames = word[MC_ACCEPT_ALL];
      cfg_o.multicast_pass = word[MC_MULTICAST];
      cfg_o.late_collision_retry = word[MC_LATE_COL];
      cfg_o.single_attempt = word[MC_SINGLE];
      cfg_o.auto_pad_strip = word[MC_PAD_STRIP];
      cfg_o.backoff_limit = word[MC_BACKOFF_HI:MC_BACKOFF_LO];
      cfg_o.deferral_abort_check = word[MC_DEFERRAL];
      cfg_o.tx_enable = word[MC_TX_EN];
      cfg_o.rx_enable = word[MC_RX_EN];
   end

endmodule

// >>> verification/mrq_phy_model.sv
// phy side model: frame ends and transmit replies
`timescale 1ns/1ns
module mrq_phy_model import mrq_pkg::*; (
   input wire logic clk_sys_i,
   input wire logic tx_start_i,
   output logic frame_done_o = 1'b0,
   output logic [13:0] frame_len_o = 14'h0000,
   output mrq_frame_stat_t frame_stat_o = '0,
   output logic tx_collision_o = 1'b0,
   output logic tx_done_o = 1'b0
);
   int collide_n = 0;
   // released lines show the inverse, so a stale value is never reused
   task automatic send(input logic [13:0] n, input mrq_frame_stat_t s);
      @(posedge clk_sys_i);
      frame_done_o <= 1'b1;
      frame_len_o <= n;
      frame_stat_o <= s;
      @(posedge clk_sys_i);
      frame_done_o <= 1'b0;
      frame_len_o <= ~n;
      frame_stat_o <= ~s;
   endtask
   always @(posedge clk_sys_i) begin
      if (tx_start_i) begin
         @(posedge clk_sys_i);
         tx_collision_o <= (collide_n > 0);
         tx_done_o <= (collide_n == 0);
         @(posedge clk_sys_i);
         tx_collision_o <= 1'b0;
         tx_done_o <= 1'b0;
         if (collide_n > 0) collide_n--;
      end
   end
endmodule

// >>> verification/test_mrq_rx_ctrl.sv
// self-checking bench for the receive queue control block
`timescale 1ns/1ns
module test_mrq_rx_ctrl import mrq_pkg::*; ;
   localparam logic [LVL_W-1:0] QB = 25'h4_0000;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ovf = 1'b0;
   logic drain = 1'b0, tx_req = 1'b0;
   logic [8:0] addr = 9'h000;
   logic [7:0] wdata = 8'h00, rdata;
   logic [13:0] dlen = 14'h0000, flen;
   logic done, acc, drop, irq, start, skip, rerr, hb, txc, txd;
   mrq_frame_stat_t fst;
   logic [LVL_W-1:0] lvl;
   mrq_mac_cfg_t cfg;
   int mismatches = 0, tests_run = 0;
   mrq_rx_ctrl #(.QUEUE_BYTES(QB)) mrq_rx_ctrl_inst (.clk_sys_i(clk),
      .arst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .frame_done_i(done), .frame_len_i(flen), .frame_stat_i(fst),
      .rx_fifo_ovf_i(ovf), .drain_i(drain), .drain_len_i(dlen),
      .frame_accept_o(acc), .frame_drop_o(drop), .queue_level_o(lvl),
      .irq_o(irq), .tx_req_i(tx_req), .tx_collision_i(txc),
      .tx_done_i(txd), .tx_start_o(start), .tx_skip_o(skip),
      .tx_retry_err_o(rerr), .hb_check_en_o(hb), .mac_cfg_o(cfg));
   mrq_phy_model mrq_phy_model_inst (.clk_sys_i(clk), .tx_start_i(start),
      .frame_done_o(done), .frame_len_o(flen), .frame_stat_o(fst),
      .tx_collision_o(txc), .tx_done_o(txd));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("compares %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic do_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [8:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic ctl(input logic [7:0] idx, input logic [7:0] d);
      wr_reg(9'h140, 8'h00);
      wr_reg(9'h141, idx);
      wr_reg(9'h142, d);
   endtask
   task automatic fr(input logic [13:0] n, input logic [8:0] s, logic a);
      mrq_phy_model_inst.send(n, s);
      #1 chk({acc, drop}, {a, !a});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic t_regs;
      logic [7:0] m [4] = '{8'h18, 8'hbc, 8'h15, 8'hec};
      chk(hb, 1'b1);
      ctl(8'h00, 8'h10);
      #1 chk(hb, 1'b0);
      for (int a = 9'h15a; a <= 9'h15e; a++) rdc(a[8:0], 8'h00);
      wr_reg(9'h150, 8'hff);
      rdc(9'h150, 8'h00);
      for (int i = 0; i < 4; i++) begin
         ctl(i[7:0], 8'hff);
         rdc(9'h142, m[i]);
      end
      chk(cfg, 32'h0000_7fff);
      chk(hb, 1'b0);
      ctl(8'h04, 8'hff);
      rdc(9'h142, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_filter;
      logic [8:0] s [7] = '{9'h100, 9'h180, 9'h040, 9'h020, 9'h010,
         9'h008, 9'h001};
      logic [7:0] m [7] = '{8'h20, 8'h60, 8'h10, 8'h08, 8'h04, 8'h0a, 8'h01};
      logic [7:0] d [7] = '{8'h5f, 8'h20, 8'h6f, 8'h77, 8'h7b, 8'h7d, 8'h7e};
      wr_reg(9'h15e, 8'h7f);
      fr(14'h0040, 9'h000, 1'b0);
      ctl(8'h03, 8'h04);
      for (int i = 0; i < 7; i++) begin
         wr_reg(9'h15e, d[i]);
         fr(14'h0040, s[i], 1'b0);
         wr_reg(9'h15e, m[i]);
         fr(14'h0040, s[i], 1'b1);
      end
      fr(14'h0040, 9'h014, 1'b1);
      chk(lvl, 25'h000_0200);
      $display("t_filter done");
   endtask
   task automatic t_wm;
      int q = 65535;
      ctl(8'h03, 8'h04);
      wr_reg(9'h15b, 8'h01);
      wr_reg(9'h15a, 8'h01);
      wr_reg(9'h15c, 8'h01);
      for (int i = 0; i < 4; i++) fr(14'h3fff, 9'h000, 1'b1);
      fr(14'h0003, 9'h000, 1'b1);
      tick(1);
      chk(irq, 1'b0);
      fr(14'h0001, 9'h000, 1'b1);
      tick(1);
      chk(irq, 1'b1);
      rdc(9'h15d, 8'h02);
      rdc(9'h15d, 8'h00);
      wr_reg(9'h15c, 8'h02);
      @(posedge clk);
      drain <= 1'b1;
      dlen <= 14'h0001;
      @(posedge clk);
      drain <= 1'b0;
      dlen <= 14'h3ffe;
      tick(1);
      chk(irq, 1'b1);
      rdc(9'h15d, 8'h01);
      while (q + 16383 <= QB) begin
         fr(14'h3fff, 9'h000, 1'b1);
         q += 16383;
      end
      fr(14'h3fff, 9'h000, 1'b0);
      chk(lvl, q);
      rdc(9'h15d, 8'h06);
      wr_reg(9'h15c, 8'h00);
      @(posedge clk);
      ovf <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
      tick(2);
      chk(irq, 1'b0);
      wr_reg(9'h15c, 8'h08);
      tick(2);
      chk(irq, 1'b1);
      rdc(9'h15d, 8'h08);
      $display("t_wm done");
   endtask
   task automatic tx_run(int n, logic [7:0] b2, int e, logic [2:0] k);
      int st = 0;
      logic lo = 1'b0, fin = 1'b0;
      logic [2:0] how = 3'b000;
      ctl(8'h02, b2);
      mrq_phy_model_inst.collide_n = n;
      @(posedge clk);
      tx_req <= 1'b1;
      repeat (300) begin
         @(posedge clk);
         if (lo) tx_req <= 1'b0;
         if (fin) break;
         #1 st += start;
         lo = st == e && (txc || txd);
         how = {rerr, skip, txd};
         fin = |how;
      end
      if (!fin) begin
         mismatches++;
         stop_test();
      end else begin
         chk(st, e);
         chk(how, k);
      end
   endtask
   task automatic t_tx;
      int st = 0;
      @(posedge clk);
      tx_req <= 1'b1;
      repeat (20) begin
         @(posedge clk);
         #1 st += start;
      end
      @(posedge clk);
      tx_req <= 1'b0;
      chk(st, 0);
      ctl(8'h03, 8'h08);
      #1 chk(cfg, 32'h0000_0002);
      tx_run(16, 8'h00, 16, 3'b100);
      tx_run(2, 8'h00, 3, 3'b001);
      tx_run(1, 8'h04, 1, 3'b010);
      $display("t_tx done");
   endtask
   initial begin
      forever #25 clk = ~clk;
   end
   initial begin
      do_reset();
      t_regs();
      do_reset();
      t_filter();
      do_reset();
      t_wm();
      do_reset();
      t_tx();
      stop_test();
   end
endmodule
